/* logic/nsmx_unit.sv */
/*
 * Top of the nibble swap / mask test / exclusive OR execution unit.
 * Registers one operation per issue strobe and holds the halt state.
 * Assumes the register file supplies operands with the issue strobe,
 * and that a DMA engine outside uses dma_allowed to run during a wait.
 */
`timescale 1ns/1ps
// Operation
// - Swap exchanges low and high nibbles of destination and writes it back.
// - Swap: zero on zero result, sign is bit 7; D and H kept.
// - Complement mask test ANDs inverted destination with mask; flags only.
// - Complement mask test: zero when all masked destination bits are one.
// - Complement mask test: zero, sign set, overflow cleared, others kept.
// - Mask test ANDs destination with mask; operands unchanged.
// - Mask test: zero when all masked destination bits are zero.
// - Mask test and XOR: overflow cleared, zero and sign from result.
// - XOR writes bitwise difference into destination; source unchanged.
// - Wait halts execution until an interrupt, DMA still permitted.
// - Wait ends on internal interrupt, fast interrupt included.
// - Wait leaves every flag unchanged.
module nsmx_unit
    import nsmx_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              ce,
    input  wire logic              issue,
    input  wire logic [2:0]        op_sel,
    input  wire logic [DATA_W-1:0] dst_in,
    input  wire logic [DATA_W-1:0] src_in,
    input  wire logic [FLAG_W-1:0] flags_in,
    input  wire logic              int_irq,
    input  wire logic              fast_irq,
    output logic [DATA_W-1:0]      result_ff,
    output logic [FLAG_W-1:0]      flags_ff,
    output logic                   dst_we_ff,
    output logic                   done_ff,
    output logic                   halt_ff,
    output logic                   dma_allowed_ff
);

    // ********************************************************
    // Internal wiring
    // ********************************************************
    nsmx_alu_if alu_bus ();

    logic              halted;
    logic              take;
    logic [DATA_W-1:0] nxt_result;
    logic [FLAG_W-1:0] nxt_flags;
    logic              nxt_dst_we;
    logic              nxt_done;
    logic              nxt_halt;
    nsmx_op_type       op_dec;

    // Decode operation selector; unknown codes act as no operation
    always_comb
    begin
        op_dec = NSMX_OP_NONE;
        unique case (op_sel)
            3'h1:    op_dec = NSMX_OP_SWAP;
            3'h2:    op_dec = NSMX_OP_COMPLEMENT_MASK_TEST;
            3'h3:    op_dec = NSMX_OP_MASK_TEST_OP;
            3'h4:    op_dec = NSMX_OP_XOR;
            3'h5:    op_dec = NSMX_OP_INTERRUPT_WAIT_HALT;
            default: op_dec = NSMX_OP_NONE;
        endcase
    end

    // Issue is refused while halted
    assign take = issue && !halted;

    // Feed operands to the logic and halt blocks
    assign alu_bus.dst        = dst_in;
    assign alu_bus.src        = src_in;
    assign alu_bus.flags_in   = flags_in;
    assign alu_bus.op         = take ? op_dec : NSMX_OP_NONE;
    assign alu_bus.wait_start = take && (op_dec == NSMX_OP_INTERRUPT_WAIT_HALT);

    // ********************************************************
    // Submodules
    // ********************************************************
    nsmx_logic u_logic
    (
        .bus (alu_bus.alu)
    );

    nsmx_halt u_halt
    (
        .clk      (clk),
        .srst     (srst),
        .ce       (ce),
        .bus      (alu_bus.halt),
        .int_irq  (int_irq),
        .fast_irq (fast_irq),
        .halted   (halted)
    );

    // ********************************************************
    // Output next values
    // ********************************************************
    // Results register on each accepted issue; write strobe one cycle
    always_comb
    begin
        nxt_result = result_ff;
        nxt_flags  = flags_ff;
        nxt_dst_we = 1'b0;
        nxt_done   = 1'b0;
        nxt_halt   = (halted && !(int_irq || fast_irq))
                   || (alu_bus.wait_start && !(int_irq || fast_irq));
        if (take)
        begin
            nxt_result = alu_bus.result;
            nxt_flags  = alu_bus.flags_out;
            nxt_dst_we = alu_bus.write_dst;
            nxt_done   = 1'b1;
        end
    end

    // Output registers
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            result_ff      <= DATA_RST;
            flags_ff       <= FLAG_RST;
            dst_we_ff      <= 1'b0;
            done_ff        <= 1'b0;
            halt_ff        <= 1'b0;
            dma_allowed_ff <= 1'b1;
        end
        else if (ce)
        begin
            result_ff      <= nxt_result;
            flags_ff       <= nxt_flags;
            dst_we_ff      <= nxt_dst_we;
            done_ff        <= nxt_done;
            halt_ff        <= nxt_halt;
            dma_allowed_ff <= 1'b1;
        end
    end

endmodule

/* logic/nsmx_pkg.sv */
/*
 * Package for the nibble swap / mask test / exclusive OR unit.
 * Holds operation codes, flag bit positions and reset values.
 * Assumes nothing of its surroundings.
 */
package nsmx_pkg;

    // ********************************************************
    // Widths and flag positions
    // ********************************************************
    localparam int DATA_W = 8;
    localparam int FLAG_W = 8;
    localparam int FLAG_C = 7;
    localparam int FLAG_Z = 6;
    localparam int FLAG_S = 5;
    localparam int FLAG_V = 4;
    localparam int FLAG_D = 3;
    localparam int FLAG_H = 2;
    localparam int SIGN_BIT = 7;
    localparam int NIB_W = 4;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] FLAG_RST = 8'h00;

    // ********************************************************
    // Operation selection
    // ********************************************************
    typedef enum logic [2:0]
    {
        NSMX_OP_NONE                 = 3'h0,
        NSMX_OP_SWAP                 = 3'h1,
        NSMX_OP_COMPLEMENT_MASK_TEST = 3'h2,
        NSMX_OP_MASK_TEST_OP         = 3'h3,
        NSMX_OP_XOR                  = 3'h4,
        NSMX_OP_INTERRUPT_WAIT_HALT  = 3'h5
    } nsmx_op_type;

    // Halt controller states
    typedef enum logic
    {
        NSMX_RUN,
        NSMX_WAIT
    } nsmx_halt_type;

endpackage

/* logic/nsmx_alu_if.sv */
/*
 * Interface joining the unit top to its logic and halt submodules.
 * Assumes all parties share one clock.
 */
`timescale 1ns/1ps
interface nsmx_alu_if;
    import nsmx_pkg::*;

    logic [DATA_W-1:0] dst;
    logic [DATA_W-1:0] src;
    logic [FLAG_W-1:0] flags_in;
    nsmx_op_type       op;
    logic [DATA_W-1:0] result;
    logic [FLAG_W-1:0] flags_out;
    logic              write_dst;
    logic              wait_start;

    modport top
    (
        output dst,
        output src,
        output flags_in,
        output op,
        input  result,
        input  flags_out,
        input  write_dst,
        output wait_start
    );

    modport alu
    (
        input  dst,
        input  src,
        input  flags_in,
        input  op,
        output result,
        output flags_out,
        output write_dst
    );

    modport halt
    (
        input  wait_start
    );
endinterface

/* logic/nsmx_logic.sv */
/*
 * Combinational result and flag logic for the five operations.
 * Assumes operands and current flags are stable during the issue cycle.
 */
`timescale 1ns/1ps
module nsmx_logic
    import nsmx_pkg::*;
(
    nsmx_alu_if.alu bus
);

    logic [DATA_W-1:0] res;
    logic [FLAG_W-1:0] fl;
    logic              wr;

    // ********************************************************
    // Result and flag computation
    // ********************************************************
    // Default keeps every flag and writes nothing
    always_comb
    begin
        res = bus.dst;
        fl  = bus.flags_in;
        wr  = 1'b0;
        unique case (bus.op)
            NSMX_OP_SWAP:
            begin
                res = {bus.dst[NIB_W-1:0], bus.dst[DATA_W-1:NIB_W]};
                wr  = 1'b1;
                fl[FLAG_Z] = (res == DATA_RST);
                fl[FLAG_S] = res[SIGN_BIT];
                fl[FLAG_C] = 1'b0;                                   // Undefined, held low
                fl[FLAG_V] = 1'b0;                                   // Undefined, held low
            end
            NSMX_OP_COMPLEMENT_MASK_TEST:
            begin
                res = (~bus.dst) & bus.src;
                fl[FLAG_Z] = (res == DATA_RST);
                fl[FLAG_S] = res[SIGN_BIT];
                fl[FLAG_V] = 1'b0;
            end
            NSMX_OP_MASK_TEST_OP:
            begin
                res = bus.dst & bus.src;
                fl[FLAG_Z] = (res == DATA_RST);
                fl[FLAG_S] = res[SIGN_BIT];
                fl[FLAG_V] = 1'b0;
            end
            NSMX_OP_XOR:
            begin
                res = bus.dst ^ bus.src;
                wr  = 1'b1;
                fl[FLAG_Z] = (res == DATA_RST);
                fl[FLAG_S] = res[SIGN_BIT];
                fl[FLAG_V] = 1'b0;
            end
            NSMX_OP_INTERRUPT_WAIT_HALT:
            begin
                fl = bus.flags_in;
            end
            default:
            begin
                fl = bus.flags_in;
            end
        endcase
    end

    // Drive interface outputs
    assign bus.result    = res;
    assign bus.flags_out = fl;
    assign bus.write_dst = wr;

endmodule

/* logic/nsmx_halt.sv */
/*
 * Halt controller for the wait-for-interrupt operation.
 * Assumes interrupt inputs are synchronous single-cycle or level requests.
 */
`timescale 1ns/1ps
module nsmx_halt
    import nsmx_pkg::*;
(
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic ce,
    nsmx_alu_if.halt  bus,
    input  wire logic int_irq,
    input  wire logic fast_irq,
    output logic      halted
);

    nsmx_halt_type state_ff;
    nsmx_halt_type nxt_state;

    // ********************************************************
    // Next state
    // ********************************************************
    // Wait is entered on issue when no interrupt is present, and left on any internal or fast interrupt
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            NSMX_RUN:
            begin
                if (bus.wait_start && !(int_irq || fast_irq))
                    nxt_state = NSMX_WAIT;
            end
            NSMX_WAIT:
            begin
                if (int_irq || fast_irq)
                    nxt_state = NSMX_RUN;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (srst)
            state_ff <= NSMX_RUN;
        else if (ce)
            state_ff <= nxt_state;
    end

    assign halted = (state_ff == NSMX_WAIT);

endmodule

/* sim/nsmx_unit_props.sv */
/*
 * Port checker for the nibble swap / mask test / xor unit.
 * Assumes one clock and srst synchronous, active high.
 */
`timescale 1ns/1ps
module nsmx_unit_props
    import nsmx_pkg::*;
(
    input wire logic              clk,
    input wire logic              srst,
    input wire logic              ce,
    input wire logic              issue,
    input wire logic [2:0]        op_sel,
    input wire logic [DATA_W-1:0] dst_in,
    input wire logic [DATA_W-1:0] src_in,
    input wire logic [FLAG_W-1:0] flags_in,
    input wire logic              int_irq,
    input wire logic              fast_irq,
    input wire logic [DATA_W-1:0] result_ff,
    input wire logic [FLAG_W-1:0] flags_ff,
    input wire logic              dst_we_ff,
    input wire logic              done_ff,
    input wire logic              halt_ff,
    input wire logic              dma_allowed_ff
);
    // ****************
    // Issue sequences
    // ****************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_acc(logic [2:0] code);
        ce && issue && !halt_ff && op_sel == code;
    endsequence
    sequence s_wait_enter;
        s_acc(3'h5) ##0 (!int_irq && !fast_irq);
    endsequence
    // Results, write strobes and flags one edge after issue
    a_swap_result: assert property (s_acc(3'h1) |=> dst_we_ff
        && result_ff == {$past(dst_in[3:0]), $past(dst_in[7:4])}) else $error("swap result wrong");
    a_swap_flags: assert property (s_acc(3'h1) |=> flags_ff[6:5] == {result_ff == 8'h00, result_ff[7]}
        && flags_ff[3:0] == $past(flags_in[3:0])) else $error("swap flags wrong");
    a_cmt_result: assert property (s_acc(3'h2) |=> !dst_we_ff
        && result_ff == (~$past(dst_in) & $past(src_in))) else $error("complement test result wrong");
    a_cmt_zero: assert property (s_acc(3'h2) |=> flags_ff[6]
        == (($past(dst_in) & $past(src_in)) == $past(src_in))) else $error("complement test zero wrong");
    a_cmt_flags: assert property (s_acc(3'h2) |=> flags_ff == {$past(flags_in[7]), flags_ff[6], result_ff[7], 1'b0,
        $past(flags_in[3:0])}) else $error("complement test flags wrong");
    a_mt_zero: assert property (s_acc(3'h3) |=> !dst_we_ff
        && flags_ff[6] == (($past(dst_in) & $past(src_in)) == 8'h00)) else $error("mask test zero wrong");
    a_mt_xor_flags: assert property (ce && issue && !halt_ff && (op_sel == 3'h3 || op_sel == 3'h4) |=>
        flags_ff == {$past(flags_in[7]), result_ff == 8'h00, result_ff[7], 1'b0, $past(flags_in[3:0])})
        else $error("mask test or xor flags wrong");
    a_xor_result: assert property (s_acc(3'h4) |=> dst_we_ff
        && result_ff == ($past(dst_in) ^ $past(src_in))) else $error("xor result wrong");
    a_wait_enter: assert property (s_wait_enter |=> halt_ff && dma_allowed_ff)
        else $error("wait not entered");
    a_halt_hold: assert property (ce && halt_ff && !int_irq && !fast_irq |=> halt_ff && !done_ff)
        else $error("halt not held");
    a_wait_release: assert property (ce && halt_ff && (int_irq || fast_irq) |=> !halt_ff)
        else $error("wait not released");
    a_wait_flags: assert property (s_acc(3'h5) |=> flags_ff == $past(flags_in))
        else $error("wait changed flags");
    // Clock enable low keeps result, flags, halt, done and write strobe where they were
    a_ce_freeze: assert property (!ce |=> $stable(result_ff) && $stable(flags_ff) && $stable(halt_ff)
        && $stable(done_ff) && $stable(dst_we_ff)) else $error("outputs moved while clock enable low");
endmodule
bind nsmx_unit nsmx_unit_props i_props (.clk(clk), .srst(srst), .ce(ce), .issue(issue), .op_sel(op_sel),
    .dst_in(dst_in), .src_in(src_in), .flags_in(flags_in), .int_irq(int_irq), .fast_irq(fast_irq),
    .result_ff(result_ff), .flags_ff(flags_ff), .dst_we_ff(dst_we_ff), .done_ff(done_ff), .halt_ff(halt_ff),
    .dma_allowed_ff(dma_allowed_ff));

/* sim/tb_top.sv */
/*
 * Self-checking bench for the execution unit.
 * Assumes the unit answers one edge after an accepted issue.
 */
`timescale 1ns/1ps
module tb_top;
    import nsmx_pkg::*;
    logic              clk;
    logic              srst = 1'b1;
    logic              ce = 1'b1;
    logic              issue = 1'b0;
    logic [2:0]        op_sel = 3'h0;
    logic [DATA_W-1:0] dst_in = 8'h00;
    logic [DATA_W-1:0] src_in = 8'h00;
    logic [FLAG_W-1:0] flags_in = 8'h00;
    logic              int_irq = 1'b0;
    logic              fast_irq = 1'b0;
    logic [DATA_W-1:0] result_ff;
    logic [FLAG_W-1:0] flags_ff;
    logic              dst_we_ff;
    logic              done_ff;
    logic              halt_ff;
    logic              dma_allowed_ff;
    int                errors = 0;
    int                checks_done = 0;
    int                cycles = 0;

    nsmx_unit i_dut (.clk(clk), .srst(srst), .ce(ce), .issue(issue), .op_sel(op_sel), .dst_in(dst_in),
        .src_in(src_in), .flags_in(flags_in), .int_irq(int_irq), .fast_irq(fast_irq), .result_ff(result_ff),
        .flags_ff(flags_ff), .dst_we_ff(dst_we_ff), .done_ff(done_ff), .halt_ff(halt_ff),
        .dma_allowed_ff(dma_allowed_ff));

    // Clock and hang guard
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            errors++;
            summarize();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        if (got !== exp)
            errors++;
    endtask

    // Expected flags for tests and xor: C kept, V cleared
    function automatic logic [7:0] lf(input logic [7:0] f, input logic [7:0] r);
        return {f[7], r == 8'h00, r[7], 1'b0, f[3:0]};
    endfunction

    // Issue held high, done checked one edge later
    task automatic run_op(input logic [2:0] c, input logic [7:0] d, input logic [7:0] s, input logic [7:0] f);
        op_sel = c;
        dst_in = d;
        src_in = s;
        flags_in = f;
        issue = 1'b1;
        @(posedge clk);
        #1;
        chk({7'h00, done_ff}, 8'h01);
    endtask

    task automatic end_op;
        issue = 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic t_swap;
        run_op(3'h1, 8'h3E, 8'h00, 8'h0E);
        chk(result_ff, 8'hE3);
        chk(flags_ff & 8'h6F, 8'h2E);
        chk({7'h00, dst_we_ff}, 8'h01);
        run_op(3'h1, 8'h00, 8'h00, 8'hF0);
        chk(flags_ff & 8'h6F, 8'h40);
        end_op();
    endtask

    task automatic t_tests;
        run_op(3'h2, 8'hC7, 8'h02, 8'h9C);
        chk(result_ff, 8'h00);
        chk(flags_ff, lf(8'h9C, 8'h00));
        chk({7'h00, dst_we_ff}, 8'h00);
        run_op(3'h2, 8'h07, 8'hF0, 8'h10);
        chk(result_ff, 8'hF0);
        chk(flags_ff, lf(8'h10, 8'hF0));
        run_op(3'h3, 8'hC7, 8'h02, 8'h93);
        chk(result_ff, 8'h02);
        chk(flags_ff, lf(8'h93, 8'h02));
        chk({7'h00, dst_we_ff}, 8'h00);
        run_op(3'h3, 8'h2B, 8'h54, 8'h7F);
        chk(flags_ff, lf(8'h7F, 8'h00));
        end_op();
    endtask

    task automatic t_xor;
        logic [7:0] d[3] = '{8'hC7, 8'h2B, 8'h5A};
        logic [7:0] s[3] = '{8'h02, 8'h54, 8'h5A};
        logic [7:0] e[3] = '{8'hC5, 8'h7F, 8'h00};
        for (int i = 0; i < 3; i++)
        begin
            run_op(3'h4, d[i], s[i], 8'h9F);
            chk(result_ff, e[i]);
            chk(flags_ff, lf(8'h9F, e[i]));
            chk({7'h00, dst_we_ff}, 8'h01);
        end
        end_op();
    endtask

    // Wait, refused issue, release by one of the interrupt inputs
    task automatic t_wait(input logic use_fast);
        run_op(3'h5, 8'h11, 8'h22, 8'hA5);
        chk(flags_ff, 8'hA5);
        chk({6'h00, halt_ff, dma_allowed_ff}, 8'h03);
        op_sel = 3'h4;
        @(posedge clk);
        #1;
        chk({6'h00, done_ff, halt_ff}, 8'h01);
        int_irq = !use_fast;
        fast_irq = use_fast;
        @(posedge clk);
        #1;
        chk({7'h00, halt_ff}, 8'h00);
        int_irq = 1'b0;
        fast_irq = 1'b0;
        run_op(3'h4, 8'h0F, 8'hFF, 8'h00);
        chk(result_ff, 8'hF0);
        end_op();
    endtask

    // No-op code, clock enable freeze, then reset in the middle of a wait
    task automatic t_hold;
        run_op(3'h0, 8'h5C, 8'h00, 8'h3C);
        chk(result_ff, 8'h5C);
        chk(flags_ff, 8'h3C);
        chk({7'h00, dst_we_ff}, 8'h00);
        ce = 1'b0;
        op_sel = 3'h4;
        src_in = 8'h0F;
        @(posedge clk);
        #1;
        chk({6'h00, done_ff, dst_we_ff}, 8'h02);
        chk(result_ff, 8'h5C);
        chk(flags_ff, 8'h3C);
        ce = 1'b1;
        @(posedge clk);
        #1;
        chk(result_ff, 8'h53);
        chk({7'h00, dst_we_ff}, 8'h01);
        op_sel = 3'h5;
        @(posedge clk);
        #1;
        chk({7'h00, halt_ff}, 8'h01);
        srst = 1'b1;
        issue = 1'b0;
        @(posedge clk);
        #1;
        srst = 1'b0;
        chk({halt_ff, dst_we_ff, done_ff, dma_allowed_ff, 4'h0}, 8'h10);
        chk(result_ff, 8'h00);
        chk(flags_ff, 8'h00);
    endtask

    task automatic summarize;
        $display("errors %0d checks_done %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        #1;
        srst = 1'b0;
        chk({halt_ff, dst_we_ff, done_ff, dma_allowed_ff, 4'h0}, 8'h10);
        t_swap();
        t_tests();
        t_xor();
        t_wait(1'b0);
        t_wait(1'b1);
        t_hold();
        summarize();
    end
endmodule
